// File: dic_consts.vh
// constants for the dsp interrupt controller: offsets, fields, resets, levels
`ifndef DIC_CONSTS_VH
`define DIC_CONSTS_VH
`define DIC_OFF_MASK      4'h0
`define DIC_OFF_LATCH     4'h1
`define DIC_OFF_CTRL      4'h2
`define DIC_OFF_PRIO_LO   4'h3
`define DIC_OFF_PRIO_MID  4'h4
`define DIC_OFF_PRIO_HI   4'h5
`define DIC_OFF_FLAGCFG   4'h6
`define DIC_OFF_FLAGSW    4'h7
`define DIC_OFF_STACK     4'h8
`define DIC_OFF_STAT      4'h9
`define DIC_OFF_STAT_CLR  4'ha
`define DIC_OFF_STAT_EN   4'hb
`define DIC_OFF_VECTOR    4'hc
`define DIC_CTRL_NEST     4
`define DIC_CTRL_GIE      5
`define DIC_CTRL_BIAS     7
`define DIC_CTRL_PCSTK    10
`define DIC_CTRL_LPSTK    11
`define DIC_CTRL_WMASK    16'h0cb0
`define DIC_BIT_RESET     0
`define DIC_BIT_PWRDN     1
`define DIC_BIT_STACK     2
`define DIC_BIT_EMUK      3
`define DIC_USER_BASE     4
`define DIC_LEVEL_SHARED  4'hb
`define DIC_VEC_STEP      24'h000020
`define DIC_VEC_NOBOOT    24'h010000
`define DIC_MASK_RESET    16'h0000
`define DIC_CTRL_RESET    16'h0000
`define DIC_PC_DEPTH      33
`define DIC_LOOP_DEPTH    8
`define DIC_STAT_DEPTH    16
`define DIC_PC_LOW        3
`define DIC_PC_HIGH       28
`define DIC_FLAG_LEVEL    2'h0
`define DIC_FLAG_RISE     2'h1
`define DIC_FLAG_FALL     2'h2
`define DIC_FLAG_BOTH     2'h3
`endif

// File: dic_status_stack.v
// status stack memory: pushed on interrupt entry, popped on return
`timescale 1ns/100ps
module dic_status_stack #(
  parameter DEPTH = 16,                   // entries
  parameter AW    = 4,                    // address width
  parameter DW    = 16                    // status word width
) (
  input  wire          clk_sys,           // core clock
  input  wire          sys_rst,           // sync reset, high
  input  wire          push,              // store status
  input  wire          pop,               // retrieve status
  input  wire [DW-1:0] wdata,             // status to store
  output reg  [DW-1:0] rdata,             // popped status, registered
  output reg  [AW:0]   level              // entries held
);
  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      level <= {(AW+1){1'b0}};
      rdata <= {DW{1'b0}};
    end
    else if (push && level < DEPTH)
    begin
      mem[level[AW-1:0]] <= wdata;
      level              <= level + 1'b1;
    end
    else if (pop && level != 0)
    begin
      rdata <= mem[level[AW-1:0] - 1'b1];
      level <= level - 1'b1;
    end
  end
endmodule // dic_status_stack

// File: dic_interrupt_controller.v
// dsp interrupt controller: latch, mask, priority, vectors, stacks, flag pins
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "dic_consts.vh"
// What this block does
// - seventeen sources prioritised, emulator included
// - lower bit wins; vectors step 0x20
// - no-boot mode moves vectors to 0x10000
// - per-id priority field selects user slot
// - ids 0-11 reset to id; others 11
// - level 11 all alias to bit 15
// - latch AND mask, highest pending chosen
// - reset, powerdown, emulator unmaskable; gie blocks powerdown
// - control bit4 nesting, bit5 global enable
// - bits 10,11 stack irq enables; bit7 rounding
// - software writes force or clear latch bits
// - pc 33, loop 8, status 16 stacks
// - stack irq below three or above 28
// - global on/off instructions override control writes
// - only reset and emulator requests served after reset
// - flag pins level, edge, both, software
module dic_interrupt_controller #(
  parameter NPER  = 15,                   // peripheral ids
  parameter NFLAG = 16                    // flag pins
) (
  input  wire              clk_sys,       // core clock 125 MHz
  input  wire              sys_rst,       // sync reset, high
  input  wire [3:0]        reg_addr,      // register index
  input  wire [15:0]       reg_wdata,     // write data
  input  wire              reg_wr,        // write strobe
  input  wire              reg_rd,        // read strobe
  output reg  [15:0]       reg_rdata,     // read data, cycle after strobe
  input  wire [NPER-1:0]   periph_req,    // peripheral request pulses
  input  wire [NFLAG-1:0]  flag_pin,      // flag pins, asynchronous
  input  wire              emu_req,       // emulator request pulse
  input  wire              rst_req,       // reset interrupt pulse
  input  wire              pwrdn_req,     // power-down request pulse
  input  wire              emuk_req,      // emulation kernel request pulse
  input  wire              no_boot,       // run from external memory
  input  wire              global_irq_on_instr,  // enable servicing
  input  wire              global_irq_off_instr, // disable servicing
  input  wire              pc_push,       // sequencer pc push
  input  wire              pc_pop,        // sequencer pc pop
  input  wire              loop_push,     // loop stack push
  input  wire              loop_pop,      // loop stack pop
  input  wire              irq_return,    // return from service routine
  input  wire              irq_ack,       // sequencer takes irq_vector
  output reg               irq_valid,     // an interrupt awaits service
  output reg  [23:0]       irq_vector,    // vector of chosen interrupt
  output reg               emu_valid,     // emulator interrupt pending
  output wire [15:0]       status_restore,// status popped on return
  output wire              biased_round,  // mac biased rounding enable
  output wire              irq_out        // level event interrupt
);
  reg  [15:0] interrupt_mask_bits;
  reg  [15:0] interrupt_latch;
  reg  [15:0] interrupt_control;
  reg  [3:0]  prio [0:NPER-1];
  reg  [31:0] flag_mode;
  reg  [15:0] flag_sw;
  reg  [15:0] flag_meta;
  reg  [15:0] flag_sync;
  reg  [15:0] flag_prev;
  reg  [5:0]  pc_level;
  reg  [3:0]  loop_level;
  reg  [15:0] active;
  reg  [2:0]  evt_stat;
  reg  [2:0]  evt_en;
  reg  [15:0] next_latch;
  reg  [15:0] user_req;
  reg  [15:0] pending;
  reg  [4:0]  sel;
  reg  [3:0]  offer_bit;
  reg         flag_a;
  reg         flag_b;
  reg  [15:0] flag_hit;
  integer     i;
  integer     j;
  integer     m;
  wire [4:0]  stat_level;
  wire        stack_cond;
  wire        gie;
  wire        nest;
  wire [2:0]  next_evt;

  assign gie          = interrupt_control[`DIC_CTRL_GIE];
  assign nest         = interrupt_control[`DIC_CTRL_NEST];
  assign biased_round = interrupt_control[`DIC_CTRL_BIAS];

  // lowest set bit index, 16 when empty
  function [4:0] first_set;
    input [15:0] v;
    integer k;
    begin
      first_set = 5'h10;
      for (k = 15; k >= 0; k = k - 1)
        if (v[k])
          first_set = k[4:0];
    end
  endfunction

  // latch bit for a priority level
  function [3:0] slot_of;
    input [3:0] p;
    begin
      slot_of = (p >= `DIC_LEVEL_SHARED) ? 4'hf : p + 4'h4;
    end
  endfunction

  dic_status_stack #(
    .DEPTH (`DIC_STAT_DEPTH),
    .AW    (4),
    .DW    (16)
  ) u_stat (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .push    (irq_ack && irq_valid),
    .pop     (irq_return),
    .wdata   (interrupt_mask_bits),
    .rdata   (status_restore),
    .level   (stat_level)
  );

  // flag pins cross into the core clock through two flops
  always @(posedge clk_sys)
  begin
    flag_meta <= flag_pin;
    flag_sync <= flag_meta;
    // no reset: a pin idling high must not look like a fresh edge
    flag_prev <= flag_sync;
  end

  // flag sensing per pin, plus software trigger
  always @*
  begin
    flag_hit = 16'h0000;
    for (j = 0; j < NFLAG; j = j + 1)
    begin
      case (flag_mode[2*j +: 2])
        `DIC_FLAG_LEVEL: flag_hit[j] = flag_sync[j];
        `DIC_FLAG_RISE:  flag_hit[j] = flag_sync[j] & ~flag_prev[j];
        `DIC_FLAG_FALL:  flag_hit[j] = ~flag_sync[j] & flag_prev[j];
        default:         flag_hit[j] = flag_sync[j] ^ flag_prev[j];
      endcase
    end
    flag_hit = flag_hit | flag_sw;
    flag_a   = |flag_hit[7:0];
    flag_b   = |flag_hit[15:8];
  end

  // pc stack level outside its window raises the stack interrupt
  assign stack_cond = (pc_level < `DIC_PC_LOW || pc_level > `DIC_PC_HIGH)
                      && interrupt_control[`DIC_CTRL_PCSTK]
                    || (loop_level == `DIC_LOOP_DEPTH)
                      && interrupt_control[`DIC_CTRL_LPSTK];

  // request mapping into latch bits
  always @*
  begin
    user_req = 16'h0000;
    for (m = 0; m < NPER; m = m + 1)
    begin
      if (periph_req[m] || (m == 12 && flag_a) || (m == 13 && flag_b))
        user_req[slot_of(prio[m])] = 1'b1;
    end
    user_req[`DIC_BIT_RESET] = rst_req;
    user_req[`DIC_BIT_PWRDN] = pwrdn_req;
    user_req[`DIC_BIT_STACK] = stack_cond;
    user_req[`DIC_BIT_EMUK]  = emuk_req;
  end

  // reset and power-down bypass the mask; gie gates all but reset
  always @*
  begin
    pending = interrupt_latch & interrupt_mask_bits;
    pending[`DIC_BIT_RESET] = interrupt_latch[`DIC_BIT_RESET];
    pending[`DIC_BIT_PWRDN] = interrupt_latch[`DIC_BIT_PWRDN] & gie;
    if (!gie)
      pending[15:2] = 14'h0000;
    // without nesting only reset preempts; with it only lower bits do
    if (active != 16'h0000)
    begin
      if (!nest)
        pending[15:1] = 15'h0000;
      else
        pending = pending & (active - 16'h0001) & ~active;
    end
    sel = first_set(pending);
  end

  // latch: hardware set wins over software or acceptance clear
  always @*
  begin
    next_latch = interrupt_latch;
    if (reg_wr && reg_addr == `DIC_OFF_LATCH)
      next_latch = reg_wdata;
    if (irq_ack && irq_valid)
      next_latch[offer_bit] = 1'b0;
    next_latch = next_latch | user_req;
  end

  assign next_evt = {stack_cond, |flag_hit, irq_valid & irq_ack};

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      interrupt_mask_bits <= `DIC_MASK_RESET;
      interrupt_latch     <= 16'h0000;
      interrupt_control   <= `DIC_CTRL_RESET;
      flag_mode           <= 32'h00000000;
      flag_sw             <= 16'h0000;
      pc_level            <= 6'h00;
      loop_level          <= 4'h0;
      active              <= 16'h0000;
      evt_stat            <= 3'h0;
      evt_en              <= 3'h0;
      emu_valid           <= 1'b0;
      irq_valid           <= 1'b0;
      irq_vector          <= 24'h000000;
      offer_bit           <= 4'h0;
      reg_rdata           <= 16'h0000;
      for (i = 0; i < NPER; i = i + 1)
        prio[i] <= (i < 12) ? i[3:0] : `DIC_LEVEL_SHARED;
    end
    else
    begin
      interrupt_latch <= next_latch;
      flag_sw         <= 16'h0000;
      if (global_irq_on_instr)
        interrupt_control[`DIC_CTRL_GIE] <= 1'b1;
      else if (global_irq_off_instr)
        interrupt_control[`DIC_CTRL_GIE] <= 1'b0;
      if (reg_wr)
      begin
        case (reg_addr)
          `DIC_OFF_MASK:
            interrupt_mask_bits <= reg_wdata;
          `DIC_OFF_CTRL:
            if (!global_irq_on_instr && !global_irq_off_instr)
              interrupt_control <= reg_wdata & `DIC_CTRL_WMASK;
          `DIC_OFF_PRIO_LO:
            for (i = 0; i < 4; i = i + 1)
              prio[i] <= reg_wdata[4*i +: 4];
          `DIC_OFF_PRIO_MID:
            for (i = 0; i < 4; i = i + 1)
              prio[i+4] <= reg_wdata[4*i +: 4];
          `DIC_OFF_PRIO_HI:
            for (i = 0; i < 4; i = i + 1)
              prio[i+8] <= reg_wdata[4*i +: 4];
          `DIC_OFF_FLAGCFG:
            flag_mode <= {reg_wdata, reg_wdata};
          `DIC_OFF_FLAGSW:
            flag_sw <= reg_wdata;
          `DIC_OFF_STAT_EN:
            evt_en <= reg_wdata[2:0];
          default:
            ;
        endcase
      end
      // id 12-14 sit in the hi word's second group; reuse the lane
      if (reg_wr && reg_addr == `DIC_OFF_PRIO_HI + 4'h1)
        for (i = 12; i < NPER; i = i + 1)
          prio[i] <= reg_wdata[4*(i-12) +: 4];
      // stacks: track pc and loop depths
      if (pc_push && !pc_pop && pc_level < `DIC_PC_DEPTH)
        pc_level <= pc_level + 6'h01;
      else if (pc_pop && !pc_push && pc_level != 6'h00)
        pc_level <= pc_level - 6'h01;
      if (loop_push && !loop_pop && loop_level < `DIC_LOOP_DEPTH)
        loop_level <= loop_level + 4'h1;
      else if (loop_pop && !loop_push && loop_level != 4'h0)
        loop_level <= loop_level - 4'h1;
      // emulator sits above everything, no bit and no vector
      if (emu_req)
        emu_valid <= 1'b1;
      else if (irq_ack && emu_valid)
        emu_valid <= 1'b0;
      // in-service tracking for nesting
      if (irq_ack && irq_valid)
        active <= active | (16'h0001 << offer_bit);
      else if (irq_return && active != 16'h0000)
        active <= active & (active - 16'h0001);
      irq_valid  <= (sel != 5'h10) && !(irq_ack && irq_valid);
      irq_vector <= (no_boot ? `DIC_VEC_NOBOOT : 24'h000000)
                    + {15'h0000, sel[3:0], 5'h00};
      // a take clears the bit behind the offered vector, not a newer winner
      offer_bit  <= sel[3:0];
      // sticky events: set wins over clear
      evt_stat <= (evt_stat & ~((reg_wr && reg_addr == `DIC_OFF_STAT_CLR)
                  ? reg_wdata[2:0] : 3'h0)) | next_evt;
      if (reg_rd)
      begin
        case (reg_addr)
          `DIC_OFF_MASK:     reg_rdata <= interrupt_mask_bits;
          `DIC_OFF_LATCH:    reg_rdata <= interrupt_latch;
          `DIC_OFF_CTRL:     reg_rdata <= interrupt_control;
          `DIC_OFF_PRIO_LO:  reg_rdata <= {prio[3], prio[2], prio[1], prio[0]};
          `DIC_OFF_PRIO_MID: reg_rdata <= {prio[7], prio[6], prio[5], prio[4]};
          `DIC_OFF_PRIO_HI:  reg_rdata <= {prio[11], prio[10], prio[9], prio[8]};
          4'hd:              reg_rdata <= {4'h0, prio[14], prio[13], prio[12]};
          `DIC_OFF_FLAGCFG:  reg_rdata <= flag_mode[15:0];
          `DIC_OFF_STACK:    reg_rdata <= {loop_level, stat_level[3:0], 2'h0, pc_level};
          `DIC_OFF_STAT:     reg_rdata <= {13'h0000, evt_stat};
          `DIC_OFF_STAT_EN:  reg_rdata <= {13'h0000, evt_en};
          `DIC_OFF_VECTOR:   reg_rdata <= irq_vector[15:0];
          default:           reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  assign irq_out = |(evt_stat & evt_en);
endmodule // dic_interrupt_controller

// File: dic_chk.sv
// port-level assertions for the dsp interrupt controller
`timescale 1ns/100ps
module dic_chk (
  input wire        clk_sys,              // core clock
  input wire        sys_rst,              // sync reset
  input wire [3:0]  reg_addr,             // register index
  input wire [15:0] reg_wdata,            // write data
  input wire        reg_wr,               // write strobe
  input wire        reg_rd,               // read strobe
  input wire [15:0] reg_rdata,            // read data
  input wire        rst_req,              // reset interrupt
  input wire        no_boot,              // vector offset mode
  input wire        global_irq_on_instr,  // global on
  input wire        global_irq_off_instr, // global off
  input wire        irq_ack,              // vector taken
  input wire        irq_valid,            // vector offered
  input wire [23:0] irq_vector,           // offered vector
  input wire        biased_round,         // rounding enable
  input wire        irq_out               // event interrupt
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_quiet;
    $fell(sys_rst) |-> !irq_valid && !irq_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output active after reset");
  property p_vec;
    irq_valid |-> irq_vector[4:0] == 5'h00 && irq_vector[15:9] == 7'h00
      && irq_vector[23:17] == 7'h00;
  endproperty
  a_vec: assert property (p_vec) else $error("vector off the table");
  property p_boot;
    irq_valid && no_boot == $past(no_boot) |-> irq_vector[16] == no_boot;
  endproperty
  a_boot: assert property (p_boot) else $error("vector offset wrong");
  property p_ack;
    irq_ack && irq_valid |=> !irq_valid;
  endproperty
  a_ack: assert property (p_ack) else $error("request still offered after take");
  property p_resv;
    reg_rd && reg_addr == 4'h2 |=> (reg_rdata & 16'hf34f) == 16'h0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved control bit reads set");
  // an instruction in the same cycle wins over the write
  property p_round;
    reg_wr && reg_addr == 4'h2 && !global_irq_on_instr && !global_irq_off_instr
      |=> biased_round == $past(reg_wdata[7]);
  endproperty
  a_round: assert property (p_round) else $error("rounding enable not written");
  property p_rst;
    rst_req |-> ##[2:4] irq_valid && irq_vector[15:0] == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset interrupt not offered");
  property p_off;
    global_irq_off_instr && !global_irq_on_instr |=> ##1 !irq_valid
      || irq_vector[8:0] == 9'h000;
  endproperty
  a_off: assert property (p_off) else $error("offer while globally off");

  c_ack: cover property (irq_ack);
  c_boot: cover property (irq_valid && no_boot);
  c_rst: cover property (rst_req);
  c_out: cover property (irq_out);
endmodule // dic_chk

bind dic_interrupt_controller dic_chk u_dic_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_req(rst_req),
  .no_boot(no_boot), .global_irq_on_instr(global_irq_on_instr),
  .global_irq_off_instr(global_irq_off_instr), .irq_ack(irq_ack), .irq_valid(irq_valid),
  .irq_vector(irq_vector), .biased_round(biased_round), .irq_out(irq_out)
);

// File: dic_seq_model.sv
// sequencer stand-in: takes offered vectors and returns from each routine
`timescale 1ns/100ps
module dic_seq_model (
  input  wire clk_sys,    // core clock
  input  wire sys_rst,    // sync reset
  input  wire slow,       // wait before taking
  input  wire irq_valid,  // vector offered
  output reg  irq_ack,    // vector taken
  output reg  irq_return  // routine finished
);
  reg [3:0] cnt;
  reg       busy;

  // one routine at a time, so each return matches the last take
  always @(posedge clk_sys)
  begin
    irq_ack    <= 1'b0;
    irq_return <= 1'b0;
    cnt        <= 4'h0;
    if (sys_rst)
      busy <= 1'b0;
    else if (busy)
    begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'h4)
      begin
        irq_return <= 1'b1;
        busy       <= 1'b0;
        cnt        <= 4'h0;
      end
    end
    else if (irq_valid)
    begin
      cnt <= cnt + 4'h1;
      if (!slow || cnt == 4'h5)
      begin
        irq_ack <= 1'b1;
        busy    <= 1'b1;
        cnt     <= 4'h0;
      end
    end
  end
endmodule // dic_seq_model

// File: test_dsp_interrupt_controller.sv
// self-checking bench for the dsp interrupt controller
`timescale 1ns/100ps
module test_dsp_interrupt_controller;
  typedef struct packed {logic [3:0] id; logic nb; logic [23:0] vec;} dic_row_t;
  reg         clk_sys = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [15:0] reg_wdata = 16'h0000;
  reg         reg_wr = 1'b0, reg_rd = 1'b0, no_boot = 1'b0, slow = 1'b0, emu_req = 1'b0;
  reg  [15:0] flag_pin = 16'h0000;
  reg  [14:0] periph_req = 15'h0000;
  reg  [5:0]  ctl = 6'h00;
  wire        rst_req = ctl[5], pc_pop = ctl[4], pc_push = ctl[3], pwrdn_req = ctl[2];
  wire        global_irq_on_instr = ctl[1], global_irq_off_instr = ctl[0];
  wire [15:0] reg_rdata;
  wire [23:0] irq_vector;
  wire        irq_valid, irq_ack, irq_return, irq_out, biased_round, emu_valid;
  wire [15:0] status_restore;
  reg  [23:0] v;
  reg  [15:0] d;
  reg  [23:0] took[$];
  integer     i, failures = 0, total_checks = 0;
  dic_row_t   rows[6] = '{'{4'h0, 1'b0, 24'h000080}, '{4'h1, 1'b0, 24'h0000a0},
    '{4'h5, 1'b1, 24'h010120}, '{4'hb, 1'b0, 24'h0001e0}, '{4'hc, 1'b0, 24'h0001e0},
    '{4'he, 1'b0, 24'h0001e0}};
  reg  [3:0]  ra[6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'hd, 4'hf};
  reg  [15:0] rv[6] = '{16'h0000, 16'h3210, 16'h7654, 16'hba98, 16'h0bbb, 16'h0000};

  always #4 clk_sys = ~clk_sys;
  // mid-cycle sampling keeps the take record clear of edge races
  always @(negedge clk_sys)
    if (irq_ack === 1'b1)
      took.push_back(irq_vector);

  dic_interrupt_controller u_dic_interrupt_controller (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
    .flag_pin(flag_pin), .emu_req(emu_req), .rst_req(rst_req), .pwrdn_req(pwrdn_req),
    .emuk_req(1'b0), .no_boot(no_boot), .global_irq_on_instr(global_irq_on_instr),
    .global_irq_off_instr(global_irq_off_instr), .pc_push(pc_push), .pc_pop(pc_pop),
    .loop_push(1'b0), .loop_pop(1'b0), .irq_return(irq_return), .irq_ack(irq_ack),
    .irq_valid(irq_valid), .irq_vector(irq_vector), .emu_valid(emu_valid),
    .status_restore(status_restore),
    .biased_round(biased_round), .irq_out(irq_out)
  );
  dic_seq_model u_dic_seq_model (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow), .irq_valid(irq_valid),
    .irq_ack(irq_ack), .irq_return(irq_return)
  );

  task chk(input [23:0] got, input [23:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task wr(input [3:0] a, input [15:0] x);
  begin
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= x;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  end
  endtask
  task pulse(input [14:0] r, input [5:0] s);
  begin
    @(posedge clk_sys);
    periph_req <= r;
    ctl        <= s;
    @(posedge clk_sys);
    periph_req <= 15'h0000;
    ctl        <= 6'h00;
  end
  endtask
  // all ones means nothing was taken within the wait
  task serve;
    integer n;
  begin
    v = 24'hffffff;
    for (n = 0; n < 40 && took.size() == 0; n = n + 1)
      @(posedge clk_sys);
    if (took.size() != 0)
      v = took.pop_front();
  end
  endtask
  task finish_test;
  begin
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  initial
  begin
    #100000;
    failures = failures + 1;
    finish_test;
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (i = 0; i < 6; i = i + 1)
    begin
      rd(ra[i]);
      chk({8'h00, d}, {8'h00, rv[i]});
    end
    wr(4'h0, 16'hffff);
    pulse(15'h0002, 6'h00);
    serve;
    chk(v, 24'hffffff);
    pulse(15'h0000, 6'h02);
    serve;
    chk(v, 24'h0000a0);
    for (i = 0; i < 6; i = i + 1)
    begin
      no_boot <= rows[i].nb;
      slow    <= i[0];
      pulse(15'h0001 << rows[i].id, 6'h00);
      serve;
      chk(v, rows[i].vec);
    end
    no_boot <= 1'b0;
    wr(4'h0, 16'hffdf);
    pulse(15'h0002, 6'h00);
    serve;
    chk(v, 24'hffffff);
    wr(4'h0, 16'hffff);
    serve;
    chk(v, 24'h0000a0);
    pulse(15'h000a, 6'h00);
    serve;
    chk(v, 24'h0000a0);
    serve;
    chk(v, 24'h0000e0);
    wr(4'h3, 16'h321a);
    pulse(15'h0001, 6'h00);
    serve;
    chk(v, 24'h0001c0);
    wr(4'h1, 16'h0040);
    serve;
    chk(v, 24'h0000c0);
    pulse(15'h0000, 6'h01);
    wr(4'h1, 16'h0040);
    wr(4'h1, 16'h0000);
    pulse(15'h0000, 6'h02);
    serve;
    chk(v, 24'hffffff);
    wr(4'h0, 16'h0000);
    pulse(15'h0000, 6'h04);
    serve;
    chk(v, 24'h000020);
    pulse(15'h0000, 6'h01);
    pulse(15'h0000, 6'h04);
    serve;
    chk(v, 24'hffffff);
    pulse(15'h0000, 6'h20);
    serve;
    chk(v, 24'h000000);
    wr(4'h1, 16'h0000);
    pulse(15'h0000, 6'h02);
    // accepted-interrupt event through the level output
    wr(4'hb, 16'h0001);
    wr(4'ha, 16'h0001);
    rd(4'h9);
    chk({23'h000000, irq_out}, 24'h000000);
    pulse(15'h0000, 6'h04);
    serve;
    rd(4'h9);
    chk({8'h00, d & 16'h0001}, 24'h000001);
    chk({23'h000000, irq_out}, 24'h000001);
    wr(4'ha, 16'h0001);
    rd(4'h9);
    chk({8'h00, d & 16'h0001}, 24'h000000);
    chk({23'h000000, irq_out}, 24'h000000);
    // pc stack starts empty, so its low-water condition holds at once
    wr(4'h0, 16'h0004);
    wr(4'h2, 16'h0420);
    serve;
    chk(v, 24'h000040);
    wr(4'h2, 16'hffff);
    rd(4'h2);
    chk({8'h00, d}, 24'h000cb0);
    chk({23'h000000, biased_round}, 24'h000001);
    wr(4'h2, 16'h0020);
    wr(4'h1, 16'h0000);
    repeat (4) pulse(15'h0000, 6'h08);
    pulse(15'h0000, 6'h10);
    rd(4'h8);
    chk({18'h00000, d[5:0]}, 24'h000003);
    chk({8'h00, status_restore}, 24'h000004);
    took.delete();
    wr(4'h2, 16'h0420);
    serve;
    chk(v, 24'hffffff);
    // flag pins: rising edge on group a, software trigger on group b
    wr(4'h0, 16'h0200);
    wr(4'h6, 16'h5555);
    flag_pin <= 16'h0001;
    serve;
    chk(v, 24'h000120);
    flag_pin <= 16'h0000;
    wr(4'h7, 16'h0100);
    serve;
    chk(v, 24'h000120);
    emu_req <= 1'b1;
    @(posedge clk_sys);
    emu_req <= 1'b0;
    #1;
    chk({23'h000000, emu_valid}, 24'h000001);
    // second reset in mid-run brings every default back
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(4'h3);
    chk({8'h00, d}, 24'h003210);
    rd(4'hd);
    chk({8'h00, d}, 24'h000bbb);
    rd(4'h2);
    chk({8'h00, d}, 24'h000000);
    chk({22'h0, emu_valid, irq_valid}, 24'h000000);
    finish_test;
  end
endmodule // test_dsp_interrupt_controller
